/* hdl/lpac_clock_control.sv */
// Low-power, auxiliary and PLL switch clock control with an AHB-Lite register slave.
`timescale 1ns/10ps
`include "lpac_params.svh"

module lpac_clock_control #(
  parameter int unsigned SOSC_START_CYC = `LPAC_SOSC_START_CYC,
  parameter int unsigned POWERUP_TIMER_CYC = `LPAC_POWERUP_TIMER_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [2:0] initialSourceSelect,
  input wire logic [2:0] powerupTimerValue,
  input wire logic [1:0] switchModeFuse,
  input wire logic sleepMode,
  input wire logic watchdogEnable,
  input wire logic pllLocked,
  input wire logic frcPllTick,
  input wire logic auxOscTick,
  input wire logic primaryTick,
  output lpac_pkg::lpac_osc_en_s oscEnable,
  output logic [2:0] currentSource,
  output logic fscmEnable,
  output logic cycleClk,
  output logic auxClkTick,
  output logic auxCrystalEn,
  output logic auxExtClkEn,
  output lpac_pkg::lpac_conv_e converterSource
);

  // ==========================================
  // Declarations.
  lpac_pkg::lpac_ahb_req_s req_q;
  lpac_pkg::lpac_aux_s aux_q;
  lpac_pkg::lpac_aux_s auxAct_q;
  lpac_pkg::lpac_sw_e sw_q;
  logic [2:0] next_q;
  logic [2:0] cur_q;
  logic keepOn_q;
  logic lock_q;
  logic switchReq_q;
  logic switchEn_q;
  logic fail_safe_monitor_q;
  logic pwrtRun_q;
  logic [31:0] pwrtCnt_q;
  logic [31:0] soscCnt_q;
  logic soscReady_q;
  logic [8:0] auxCnt_q;
  logic [8:0] auxDiv;
  logic refTick;
  logic [31:0] oscWord;
  logic [31:0] auxWord;
  logic [31:0] statWord;
  logic oscWr;
  logic auxWr;
  logic destPll;
  logic usesSosc;
  logic usesLprc;
  logic usesPri;
  logic usesFrc;
  logic [2:0] target;

  // ==========================================
  // Bus address phase capture.
  always_ff @(posedge clk) begin
    if (reset) begin
      req_q <= '0;
    end else if (hready) begin
      req_q.valid <= hsel & htrans[1];
      req_q.write <= hwrite & (hsize == 3'h2);
      req_q.addr <= haddr[11:0];
    end
  end

  assign oscWr = req_q.valid & req_q.write & (req_q.addr == `LPAC_OSC_CTRL_OFS);
  assign auxWr = req_q.valid & req_q.write & (req_q.addr == `LPAC_AUX_CTRL_OFS);

  always_comb begin
    oscWord = '0;
    oscWord[`LPAC_OSC_SWITCH_BIT] = switchReq_q;
    oscWord[`LPAC_OSC_KEEPON_BIT] = keepOn_q;
    oscWord[`LPAC_OSC_LOCK_BIT] = lock_q;
    oscWord[`LPAC_OSC_NEXT_LSB +: 3] = next_q;
    oscWord[`LPAC_OSC_CUR_LSB +: 3] = cur_q;
    auxWord = '0;
    auxWord[`LPAC_AUX_DIV_LSB +: 3] = aux_q.div;
    auxWord[`LPAC_AUX_MODE_LSB +: 2] = aux_q.mode;
    auxWord[`LPAC_AUX_REFSEL_BIT] = aux_q.refSel;
    auxWord[`LPAC_AUX_PRIMSEL_BIT] = aux_q.primSel;
    statWord = {24'h000000, soscReady_q, pwrtRun_q, fail_safe_monitor_q, switchEn_q, oscEnable};
  end

  // ==========================================
  // Bus response, zero wait states, always OKAY.
  always_ff @(posedge clk) begin
    if (reset) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready & hsel & htrans[1] & ~hwrite) begin
        if (haddr[11:0] == `LPAC_OSC_CTRL_OFS) begin
          hrdata <= oscWord;
        end else if (haddr[11:0] == `LPAC_AUX_CTRL_OFS) begin
          hrdata <= auxWord;
        end else if (haddr[11:0] == `LPAC_STATUS_OFS) begin
          hrdata <= statWord;
        end else begin
          hrdata <= 32'h00000000;
        end
      end
    end
  end

  // ==========================================
  // Fuse capture at reset.
  always_ff @(posedge clk) begin
    if (reset) begin
      fail_safe_monitor_q <= (switchModeFuse == `LPAC_FAIL_SAFE_MONITOR_ON);
      switchEn_q <= ~switchModeFuse[1];
    end
  end

  // ==========================================
  // Oscillator control register and clock switch sequence.
  assign target = next_q;
  assign destPll = (target == `LPAC_SRC_PRI_PLL) | (target == `LPAC_SRC_FRC_PLL);

  always_ff @(posedge clk) begin
    if (reset) begin
      keepOn_q <= 1'b0;
      next_q <= initialSourceSelect;
      cur_q <= initialSourceSelect;
      switchReq_q <= 1'b0;
      sw_q <= lpac_pkg::SW_IDLE;
    end else begin
      case (sw_q)
        lpac_pkg::SW_IDLE: begin
          if (oscWr) begin
            keepOn_q <= hwdata[`LPAC_OSC_KEEPON_BIT];
            next_q <= hwdata[`LPAC_OSC_NEXT_LSB +: 3];
            if (hwdata[`LPAC_OSC_SWITCH_BIT] & switchEn_q) begin
              switchReq_q <= 1'b1;
              sw_q <= lpac_pkg::SW_START;
            end
          end
        end
        lpac_pkg::SW_START: begin
          if (target == cur_q) begin
            switchReq_q <= 1'b0;
            sw_q <= lpac_pkg::SW_IDLE;
          end else if (target == `LPAC_SRC_SOSC) begin
            if (soscReady_q) begin
              sw_q <= lpac_pkg::SW_LOCK;
            end
          end else begin
            sw_q <= lpac_pkg::SW_LOCK;
          end
        end
        lpac_pkg::SW_LOCK: begin
          if (~destPll | pllLocked) begin
            cur_q <= target;
            switchReq_q <= 1'b0;
            sw_q <= lpac_pkg::SW_IDLE;
          end
        end
        default: begin
          sw_q <= lpac_pkg::SW_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // PLL lock status.
  always_ff @(posedge clk) begin
    if (reset) begin
      lock_q <= 1'b0;
    end else if (sw_q == lpac_pkg::SW_START && target != cur_q) begin
      lock_q <= 1'b0;
    end else if (sw_q == lpac_pkg::SW_LOCK && destPll) begin
      lock_q <= pllLocked;
    end else if (sw_q == lpac_pkg::SW_IDLE) begin
      lock_q <= ((cur_q == `LPAC_SRC_PRI_PLL) | (cur_q == `LPAC_SRC_FRC_PLL)) & pllLocked;
    end
  end

  // ==========================================
  // Oscillator usage.
  always_comb begin
    usesSosc = (cur_q == `LPAC_SRC_SOSC) | ((sw_q != lpac_pkg::SW_IDLE) & (target == `LPAC_SRC_SOSC));
    usesLprc = (cur_q == `LPAC_SRC_LOW_POWER_RC_OSC) | ((sw_q != lpac_pkg::SW_IDLE) & (target == `LPAC_SRC_LOW_POWER_RC_OSC));
    usesPri = (cur_q[2:1] == 2'h1) | ((sw_q != lpac_pkg::SW_IDLE) & (target[2:1] == 2'h1));
    usesFrc = (cur_q[2:1] == 2'h0) | (cur_q[2:1] == 2'h3)
      | ((sw_q != lpac_pkg::SW_IDLE) & ((target[2:1] == 2'h0) | (target[2:1] == 2'h3)));
  end

  // ==========================================
  // Power-up timer, timed by the low-power RC.
  always_ff @(posedge clk) begin
    if (reset) begin
      pwrtRun_q <= (powerupTimerValue != 3'h0);
      pwrtCnt_q <= '0;
    end else if (pwrtRun_q && oscEnable.lowPowerRc) begin
      pwrtCnt_q <= pwrtCnt_q + 32'h00000001;
      if (pwrtCnt_q >= POWERUP_TIMER_CYC - 1) begin
        pwrtRun_q <= 1'b0;
      end
    end
  end

  // ==========================================
  // Oscillator enables.
  always_ff @(posedge clk) begin
    if (reset) begin
      oscEnable <= '0;
    end else begin
      oscEnable.secondary <= keepOn_q | (~sleepMode & usesSosc);
      oscEnable.primary <= ~sleepMode & usesPri;
      oscEnable.fastRc <= ~sleepMode & usesFrc;
      if (sleepMode) begin
        oscEnable.lowPowerRc <= watchdogEnable;
      end else begin
        oscEnable.lowPowerRc <= fail_safe_monitor_q | watchdogEnable | usesLprc | pwrtRun_q;
      end
    end
  end

  // ==========================================
  // Secondary crystal start-up wait.
  always_ff @(posedge clk) begin
    if (reset || !oscEnable.secondary) begin
      soscCnt_q <= '0;
      soscReady_q <= 1'b0;
    end else if (!soscReady_q) begin
      soscCnt_q <= soscCnt_q + 32'h00000001;
      soscReady_q <= (soscCnt_q >= SOSC_START_CYC - 1);
    end
  end

  // ==========================================
  // Status outputs and instruction cycle clock.
  always_ff @(posedge clk) begin
    if (reset) begin
      currentSource <= `LPAC_SRC_FRC;
      fscmEnable <= 1'b0;
      cycleClk <= 1'b0;
    end else begin
      currentSource <= cur_q;
      fscmEnable <= fail_safe_monitor_q;
      cycleClk <= ~cycleClk;
    end
  end

  // ==========================================
  // Auxiliary control register.
  always_ff @(posedge clk) begin
    if (reset) begin
      aux_q <= lpac_pkg::lpac_aux_s'(`LPAC_AUX_RESET);
    end else if (auxWr) begin
      aux_q.div <= hwdata[`LPAC_AUX_DIV_LSB +: 3];
      aux_q.mode <= hwdata[`LPAC_AUX_MODE_LSB +: 2];
      aux_q.refSel <= hwdata[`LPAC_AUX_REFSEL_BIT];
      aux_q.primSel <= hwdata[`LPAC_AUX_PRIMSEL_BIT];
    end
  end

  // ==========================================
  // Auxiliary oscillator pin modes.
  always_ff @(posedge clk) begin
    if (reset) begin
      auxCrystalEn <= 1'b0;
      auxExtClkEn <= 1'b0;
    end else begin
      auxCrystalEn <= (aux_q.mode == `LPAC_MODE_XT) | (aux_q.mode == `LPAC_MODE_HS);
      auxExtClkEn <= (aux_q.mode == `LPAC_MODE_EC);
    end
  end

  // ==========================================
  // Auxiliary reference selection and output divider.
  always_comb begin
    case (auxAct_q.div)
      3'h7: auxDiv = 9'h001;
      3'h6: auxDiv = 9'h002;
      3'h5: auxDiv = 9'h004;
      3'h4: auxDiv = 9'h008;
      3'h3: auxDiv = 9'h010;
      3'h2: auxDiv = 9'h020;
      3'h1: auxDiv = 9'h040;
      default: auxDiv = 9'h100;
    endcase
    if (auxAct_q.refSel && auxAct_q.primSel) begin
      refTick = primaryTick;
    end else if (auxAct_q.refSel) begin
      refTick = auxOscTick & (auxAct_q.mode != `LPAC_MODE_OFF);
    end else begin
      refTick = frcPllTick;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      auxAct_q <= lpac_pkg::lpac_aux_s'(`LPAC_AUX_RESET);
      auxCnt_q <= '0;
      auxClkTick <= 1'b0;
      converterSource <= lpac_pkg::CONV_FRC_PLL;
    end else begin
      auxClkTick <= 1'b0;
      if (refTick) begin
        if (auxCnt_q >= auxDiv - 9'h001) begin
          auxClkTick <= 1'b1;
          auxCnt_q <= '0;
          auxAct_q <= aux_q;
        end else begin
          auxCnt_q <= auxCnt_q + 9'h001;
        end
      end else if (auxAct_q.refSel && !auxAct_q.primSel
          && (auxAct_q.mode == `LPAC_MODE_OFF)) begin
        // A silent reference has no edge to cut, so pending settings load at once.
        auxCnt_q <= '0;
        auxAct_q <= aux_q;
      end
      if (auxAct_q.refSel && auxAct_q.primSel) begin
        converterSource <= lpac_pkg::CONV_PRIMARY;
      end else if (auxAct_q.refSel) begin
        converterSource <= lpac_pkg::CONV_AUX;
      end else begin
        converterSource <= lpac_pkg::CONV_FRC_PLL;
      end
    end
  end

endmodule // lpac_clock_control

/* hdl/lpac_params.svh */
// Constants for the low-power and auxiliary clock control block.
// Operation
// - Secondary crystal is off unless selected while awake, or held on by keep-on bit.
// - Keep-on bit, oscillator control bit 1, runs secondary crystal always, sleep too.
// - Sleep stops primary and fast RC, and low-power RC unless watchdog is on; secondary may stay.
// - Secondary crystal is system clock by reset fuse or software switch.
// - Secondary crystal clock is ready only after a start-up interval.
// - Low-power RC times the power-up timer, watchdog and fail-safe monitor.
// - Low-power RC is enabled at reset when power-up timer fuse bits are set.
// - Low-power RC stays on for monitor, watchdog or selection; else off after timer.
// - In sleep the low-power RC runs only when the watchdog is enabled.
// - Low-power RC is system clock by reset fuse or software switch.
// - Low-power RC clock is ready at once, without start-up wait.
// - Aux mode bits 12:11: 11 external, 10 crystal, 01 high-speed, 00 off.
// - Aux reference select bit 13 feeds the aux oscillator to the divider.
// - Converter uses fast RC with PLL, aux when reference bit alone set; primary when source and reference bits set.
// - Aux divider bits 10:8: 111 by 1 down to 001 by 64, 000 by 256.
// - Aux crystal modes use both secondary pins; external mode uses input pin only.
// - Instruction cycle clock is the system clock divided by two.
// - Select code 011 is primary with PLL, 001 fast RC with PLL; status mirrors.
// - Lock bit clears at reset and PLL switches, stays clear on non-PLL source.
// - Fail-safe monitor is enabled only when switch mode fuse equals 00.
`ifndef LPAC_PARAMS_SVH
`define LPAC_PARAMS_SVH

// ==========================================
// Timing.
`define LPAC_CLK_MHZ 50
`define LPAC_SOSC_START_US 1000
`define LPAC_SOSC_START_CYC (`LPAC_SOSC_START_US * `LPAC_CLK_MHZ)
`define LPAC_POWERUP_TIMER_US 64000
`define LPAC_POWERUP_TIMER_CYC (`LPAC_POWERUP_TIMER_US * `LPAC_CLK_MHZ)

// ==========================================
// Register offsets.
`define LPAC_OSC_CTRL_OFS 12'h000
`define LPAC_AUX_CTRL_OFS 12'h004
`define LPAC_STATUS_OFS 12'h008

// ==========================================
// Field positions and reset values.
`define LPAC_OSC_SWITCH_BIT 0
`define LPAC_OSC_KEEPON_BIT 1
`define LPAC_OSC_LOCK_BIT 5
`define LPAC_OSC_NEXT_LSB 8
`define LPAC_OSC_CUR_LSB 12
`define LPAC_AUX_DIV_LSB 8
`define LPAC_AUX_MODE_LSB 11
`define LPAC_AUX_REFSEL_BIT 13
`define LPAC_AUX_PRIMSEL_BIT 14
`define LPAC_AUX_RESET 16'h0000

// ==========================================
// Source codes and mode codes.
`define LPAC_SRC_FRC 3'h0
`define LPAC_SRC_FRC_PLL 3'h1
`define LPAC_SRC_PRI 3'h2
`define LPAC_SRC_PRI_PLL 3'h3
`define LPAC_SRC_SOSC 3'h4
`define LPAC_SRC_LOW_POWER_RC_OSC 3'h5
`define LPAC_MODE_OFF 2'h0
`define LPAC_MODE_HS 2'h1
`define LPAC_MODE_XT 2'h2
`define LPAC_MODE_EC 2'h3
`define LPAC_FAIL_SAFE_MONITOR_ON 2'h0

`endif

/* hdl/lpac_pkg.sv */
// Types shared by the low-power and auxiliary clock control block.
package lpac_pkg;

  typedef enum logic [1:0] {SW_IDLE, SW_START, SW_LOCK} lpac_sw_e;

  typedef enum logic [1:0] {CONV_FRC_PLL, CONV_AUX, CONV_PRIMARY} lpac_conv_e;

  typedef struct packed {
    logic primSel;
    logic refSel;
    logic [1:0] mode;
    logic [2:0] div;
  } lpac_aux_s;

  typedef struct packed {
    logic primary;
    logic fastRc;
    logic secondary;
    logic lowPowerRc;
  } lpac_osc_en_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
  } lpac_ahb_req_s;

endpackage

/* test/lpac_clock_control_assertions.sv */
// Port checker for the clock control block.
`timescale 1ns/10ps
// ==========================================
// Checker.
module lpac_check (
  input wire logic clk,
  input wire logic reset,
  input wire logic sleepMode,
  input wire logic watchdogEnable,
  input wire logic [1:0] switchModeFuse,
  input wire lpac_pkg::lpac_osc_en_s oscEnable,
  input wire logic [2:0] currentSource,
  input wire logic fscmEnable,
  input wire logic cycleClk,
  input wire logic auxCrystalEn,
  input wire logic auxExtClkEn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence asleep(logic wdt);
    (sleepMode && watchdogEnable == wdt) [*2];
  endsequence
  sequence awakeOn(logic [2:0] src);
    (currentSource == src && !sleepMode) [*2];
  endsequence
  AST_CYCLE_TOGGLE: assert property (!$past(reset) |-> cycleClk != $past(cycleClk))
    else $error("instruction clock did not toggle");
  AST_SLEEP_FAST_OFF: assert property (sleepMode [*2] |-> !oscEnable.primary && !oscEnable.fastRc)
    else $error("fast sources running in sleep");
  AST_SLEEP_LOW_POWER_RC_OSC_OFF: assert property (asleep(1'b0) |-> !oscEnable.lowPowerRc)
    else $error("low-power RC on in sleep without watchdog");
  AST_SLEEP_LOW_POWER_RC_OSC_ON: assert property (asleep(1'b1) |-> oscEnable.lowPowerRc)
    else $error("low-power RC off in sleep with watchdog");
  AST_WDT_LOW_POWER_RC_OSC: assert property ((watchdogEnable && !sleepMode) [*2] |-> oscEnable.lowPowerRc)
    else $error("low-power RC off with watchdog");
  AST_FAIL_SAFE_MONITOR_FUSE: assert property (fscmEnable |-> switchModeFuse == 2'h0)
    else $error("fail-safe enabled with wrong fuse");
  AST_AUX_PINS: assert property (!(auxCrystalEn && auxExtClkEn))
    else $error("aux crystal and external clock both on");
  AST_SOSC_SELECTED: assert property (awakeOn(3'h4) |-> oscEnable.secondary)
    else $error("secondary off while selected");
  AST_LOW_POWER_RC_OSC_SELECTED: assert property (awakeOn(3'h5) |-> oscEnable.lowPowerRc)
    else $error("low-power RC off while selected");
  AST_FAIL_SAFE_MONITOR_LOW_POWER_RC_OSC: assert property ((fscmEnable && !sleepMode) [*2] |-> oscEnable.lowPowerRc)
    else $error("low-power RC off with fail-safe monitor");
endmodule // lpac_check

bind lpac_clock_control lpac_check i_check (.clk(clk), .reset(reset), .sleepMode(sleepMode),
  .watchdogEnable(watchdogEnable), .switchModeFuse(switchModeFuse), .oscEnable(oscEnable),
  .currentSource(currentSource), .fscmEnable(fscmEnable), .cycleClk(cycleClk),
  .auxCrystalEn(auxCrystalEn), .auxExtClkEn(auxExtClkEn));

/* test/test_low_power_and_aux_clock_control.sv */
// Self-checking testbench for the clock control block.
`timescale 1ns/10ps
module test_low_power_and_aux_clock_control;
  logic clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, sleepMode = 1'b0;
  logic watchdogEnable = 1'b0, pllLocked = 1'b0, refTick = 1'b0;
  logic [2:0] initSrc = 3'h0, pwrtFuse = 3'h7;
  logic [1:0] modeFuse = 2'h1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, currentSource;
  logic hreadyout, hresp, fscmEnable, cycleClk, auxClkTick, auxCrystalEn, auxExtClkEn;
  lpac_pkg::lpac_osc_en_s oscEnable;
  lpac_pkg::lpac_conv_e converterSource;
  int bad_count = 0, n_tests = 0, cycleCount = 0, n;
  // ==========================================
  // Clock, reference ticks and the device.
  always #10 clk = ~clk;
  always @(posedge clk) refTick <= ~refTick;
  lpac_clock_control #(.SOSC_START_CYC(8), .POWERUP_TIMER_CYC(16)) i_dut (.clk(clk), .reset(reset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .initialSourceSelect(initSrc), .powerupTimerValue(pwrtFuse), .switchModeFuse(modeFuse),
    .sleepMode(sleepMode), .watchdogEnable(watchdogEnable), .pllLocked(pllLocked),
    .frcPllTick(refTick), .auxOscTick(refTick), .primaryTick(refTick), .oscEnable(oscEnable),
    .currentSource(currentSource), .fscmEnable(fscmEnable), .cycleClk(cycleClk),
    .auxClkTick(auxClkTick), .auxCrystalEn(auxCrystalEn), .auxExtClkEn(auxExtClkEn),
    .converterSource(converterSource));
  // ==========================================
  // Shared tasks.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cw(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wait_tick(output int g);
    g = 0;
    do begin
      cw(1);
      g++;
    end while (auxClkTick !== 1'b1 && g < 1200);
  endtask
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_sw();
    n = 0;
    do begin
      ahb(1'b0, 12'h000, 32'h0);
      n++;
    end while (rd[0] === 1'b1 && n < 60);
  endtask
  task automatic set_sleep(input logic s);
    @(posedge clk);
    sleepMode <= s;
    cw(3);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================
  // Scenarios.
  task automatic t_low_power_rc_osc();
    cw(1);
    chk("low_power_rc_osc at reset", 32'h1, oscEnable.lowPowerRc);
    chk("fail_safe_monitor", 32'h0, fscmEnable);
    cw(20);
    chk("low_power_rc_osc after timer", 32'h0, oscEnable.lowPowerRc);
    @(posedge clk);
    watchdogEnable <= 1'b1;
    cw(2);
    chk("low_power_rc_osc for watchdog", 32'h1, oscEnable.lowPowerRc);
  endtask
  task automatic t_regs();
    ahb(1'b0, 12'h004, 32'h0);
    chk("aux reset", 32'h0, rd);
    chk("okay response", 32'h0, hresp);
    ahb(1'b0, 12'h000, 32'h0);
    chk("source and lock", 32'h0, {rd[14:12], rd[5]});
    ahb(1'b0, 12'h00C, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  task automatic t_aux();
    int g;
    for (int m = 0; m < 4; m++) begin
      ahb(1'b1, 12'h004, m << 11);
      cw(2);
      chk("crystal pins", (m == 1 || m == 2), auxCrystalEn);
      chk("external pin", (m == 3), auxExtClkEn);
    end
    ahb(1'b1, 12'h004, 32'h00002000);
    wait_tick(g);
    cw(2);
    chk("aux reference", lpac_pkg::CONV_AUX, converterSource);
    ahb(1'b1, 12'h004, 32'h0);
    wait_tick(g);
    chk("silent reference released", 32'h1, g < 1200);
    ahb(1'b1, 12'h004, 32'h00003000);
    wait_tick(g);
    cw(2);
    chk("aux reference ticking", lpac_pkg::CONV_AUX, converterSource);
    ahb(1'b1, 12'h004, 32'h00006000);
    wait_tick(g);
    cw(2);
    chk("primary reference", lpac_pkg::CONV_PRIMARY, converterSource);
    ahb(1'b1, 12'h004, 32'h0);
    wait_tick(g);
    cw(2);
    chk("default reference", lpac_pkg::CONV_FRC_PLL, converterSource);
    for (int d = 0; d < 8; d++) begin
      ahb(1'b1, 12'h004, 32'h00003000 | (d << 8));
      for (int k = 0; k < 3; k++) begin
        wait_tick(g);
      end
      chk("aux period", 2 * ((d == 0) ? 256 : (1 << (7 - d))), g);
    end
  endtask
  task automatic t_switch();
    ahb(1'b1, 12'h000, 32'h00000401);
    wait_sw();
    chk("secondary start wait", 32'h1, n >= 4);
    chk("secondary source", 32'h4, currentSource);
    chk("secondary on", 32'h1, oscEnable.secondary);
    set_sleep(1'b1);
    chk("secondary in sleep", 32'h0, oscEnable.secondary);
    set_sleep(1'b0);
    ahb(1'b1, 12'h000, 32'h00000501);
    wait_sw();
    chk("low_power_rc_osc no wait", 32'h1, n <= 3);
    chk("low_power_rc_osc source", 32'h5, currentSource);
    chk("secondary released", 32'h0, oscEnable.secondary);
    @(posedge clk);
    watchdogEnable <= 1'b0;
    ahb(1'b1, 12'h000, 32'h00000502);
    set_sleep(1'b1);
    chk("keep-on in sleep", 32'h1, oscEnable.secondary);
    set_sleep(1'b0);
    ahb(1'b1, 12'h000, 32'h00000500);
  endtask
  task automatic t_pll();
    logic [2:0] codes [3] = '{3'h3, 3'h0, 3'h1};
    foreach (codes[i]) begin
      @(posedge clk);
      if (codes[i][0]) pllLocked <= 1'b0;
      ahb(1'b1, 12'h000, 32'h00000001 | (codes[i] << 8));
      cw(4);
      ahb(1'b0, 12'h000, 32'h0);
      if (codes[i][0]) chk("busy unlocked", 32'h2, {rd[0], rd[5]});
      @(posedge clk);
      pllLocked <= 1'b1;
      wait_sw();
      ahb(1'b0, 12'h000, 32'h0);
      chk("status code", codes[i], rd[14:12]);
      chk("lock bit", codes[i][0], rd[5]);
    end
  endtask
  task automatic t_fuse();
    @(posedge clk);
    reset <= 1'b1;
    initSrc <= 3'h4;
    pwrtFuse <= 3'h0;
    modeFuse <= 2'h0;
    watchdogEnable <= 1'b0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    cw(2);
    chk("fuse source", 32'h4, currentSource);
    chk("fail_safe_monitor from fuse", 32'h1, fscmEnable);
    cw(40);
    chk("low_power_rc_osc for fail_safe_monitor", 32'h1, oscEnable.lowPowerRc);
    ahb(1'b0, 12'h008, 32'h0);
    chk("status after fuses", 32'h000000B3, rd);
  endtask
  // ==========================================
  // Sequence and timeout.
  always @(posedge clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 40000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_low_power_rc_osc();
    t_regs();
    t_aux();
    t_switch();
    t_pll();
    t_fuse();
    tally_and_finish();
  end
endmodule // test_low_power_and_aux_clock_control
